// ### design/lba_pkg.sv
// Constants, types and register map of the backscatter accumulator
package lba_pkg;

  // Clock and timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TRIG_RATE_HZ    = 5570;
  localparam int TRIG_PERIOD_CYC = CLK_HZ / TRIG_RATE_HZ;
  localparam int SAMPLE_NS       = 100;
  localparam int SAMPLE_CYC      = (SAMPLE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

  // Widths
  localparam int PER_W  = 20;
  localparam int CNT_W  = 17;
  localparam int IDX_W  = 10;
  localparam int DAC_W  = 12;
  localparam int ADC_W  = 8;
  localparam int ACC_W  = 24;
  localparam int ADDR_W = 12;
  localparam int PROF_DEPTH = 512;

  // Reset values
  localparam logic [CNT_W-1:0] PULSES_DEF  = 17'h10000;
  localparam logic [IDX_W-1:0] SAMPLES_DEF = 10'h1F4;
  localparam logic [IDX_W-1:0] PRE_DEF     = 10'h004;
  localparam logic [DAC_W-1:0] DAC_DEF     = 12'h000;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_PERIOD    = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_PULSES    = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_SAMPLES   = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_PRE       = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_LASER_DAC = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_COMP_DAC  = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT  = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_INT_EN    = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_INT_CLR   = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_PULSE_CNT = 12'h02C;
  localparam logic [ADDR_W-1:0] OFS_PROFILE   = 12'h800;

  // Control and interrupt bit positions
  localparam int CTRL_START   = 0;
  localparam int CTRL_TEST    = 1;
  localparam int CTRL_TST_GAIN = 2;
  localparam int CTRL_TST_BW  = 3;
  localparam int INT_DONE     = 0;
  localparam int INT_REFUSED  = 1;
  localparam int INT_W        = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_RUN} lba_st_t;

  typedef struct packed {
    logic             test_mode;
    logic             tst_gain;
    logic             tst_bw;
    logic [PER_W-1:0] period;
    logic [CNT_W-1:0] pulses;
    logic [IDX_W-1:0] nsamp;
    logic [IDX_W-1:0] pre;
  } lba_cfg_t;

  typedef struct packed {
    logic             sample_stb;
    logic [IDX_W-1:0] idx;
    logic             trig;
    logic             pulse_end;
  } lba_tmr_t;

endpackage

// ### design/lba_timer.sv
// Pulse period, sample slot and trigger timing of one measurement
`timescale 1ns/10ps
module lba_timer import lba_pkg::*; #(
  parameter int DIV = SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic     clk_sys,
  input  wire logic     reset,
  // Control
  input  wire logic     run,
  input  var  lba_cfg_t cfg,
  // Timing out
  output lba_tmr_t      tmr
);

  localparam int DV_W = $clog2(DIV + 1);
  localparam logic [DV_W-1:0] DIV_LAST = DV_W'(DIV - 1);

  logic [PER_W-1:0] per_ff, nxt_per;
  logic [DV_W-1:0]  div_ff, nxt_div;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic             win_ff, nxt_win;
  logic             pend;

  always_comb begin
    pend    = run && (per_ff == cfg.period - PER_W'(1));
    nxt_per = per_ff;
    nxt_div = div_ff;
    nxt_idx = idx_ff;
    nxt_win = win_ff;
    if (!run) begin
      nxt_per = '0;
      nxt_div = '0;
      nxt_idx = '0;
      nxt_win = 1'b0;
    end else begin
      nxt_per = pend ? '0 : per_ff + PER_W'(1);
      if (per_ff == '0) begin
        nxt_win = 1'b1;
        nxt_idx = '0;
        nxt_div = '0;
      end else if (win_ff) begin
        nxt_div = (div_ff == DIV_LAST) ? '0 : div_ff + DV_W'(1); // R04
        if (div_ff == DIV_LAST) begin
          if (idx_ff == cfg.nsamp - IDX_W'(1)) begin
            nxt_win = 1'b0;
          end else begin
            nxt_idx = idx_ff + IDX_W'(1); // R07
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      per_ff <= '0;
      div_ff <= '0;
      idx_ff <= '0;
      win_ff <= 1'b0;
    end else begin
      per_ff <= nxt_per;
      div_ff <= nxt_div;
      idx_ff <= nxt_idx;
      win_ff <= nxt_win;
    end
  end

  assign tmr.sample_stb = win_ff && (div_ff == '0); // R04
  assign tmr.idx        = idx_ff;
  // Launch slot lies after the pre-launch samples
  assign tmr.trig       = win_ff && (idx_ff == cfg.pre); // R10
  assign tmr.pulse_end  = pend;

endmodule

// ### design/lba_accum.sv
// Accumulation memory with zero clear walk
`timescale 1ns/10ps
module lba_accum import lba_pkg::*; #(
  parameter int DEPTH = PROF_DEPTH,
  parameter int DW    = ACC_W,
  parameter int AW    = $clog2(PROF_DEPTH)
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Clear
  input  wire logic             clear_go,
  output logic                  clr_busy,
  output logic                  clr_done,
  // Accumulate
  input  wire logic             add_en,
  input  wire logic [AW-1:0]    add_idx,
  input  wire logic [ADC_W-1:0] add_val,
  // Read
  input  wire logic [AW-1:0]    rd_idx,
  output logic [DW-1:0]         rd_data
);

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] clr_ff, nxt_clr;
  logic          busy_ff, nxt_busy;

  always_comb begin
    clr_done = busy_ff && (clr_ff == AW'(DEPTH - 1));
    nxt_clr  = clr_ff;
    nxt_busy = busy_ff;
    if (clear_go) begin
      nxt_busy = 1'b1;
      nxt_clr  = '0;
    end else if (busy_ff) begin
      nxt_clr  = clr_ff + AW'(1);
      nxt_busy = !clr_done;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clr_ff  <= '0;
      busy_ff <= 1'b0;
    end else begin
      clr_ff  <= nxt_clr;
      busy_ff <= nxt_busy;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (busy_ff) begin
      mem[clr_ff] <= '0; // R06
    end else if (add_en) begin
      mem[add_idx] <= mem[add_idx] + DW'(add_val); // R07 R16
    end
  end

  assign clr_busy = busy_ff;
  assign rd_data  = mem[rd_idx];

endmodule

// ### design/lba_top.sv
// Backscatter accumulator: registers, run control and sample path
// Function
// R01: Host loads settings; run then completes alone
// R02: Trigger pulses at configured rate, 5.57 kHz
// R03: Normal run accumulates 65,536 pulses
// R04: One sample per 100 ns, 500 per pulse
// R05: Each sample is one unsigned byte
// R06: Memory zeroed before every run
// R07: Same delay always sums into same location
// R08: Interrupt host when pulse count reached
// R09: Host reads profile after completion interrupt
// R10: Sampling starts before laser launch
// R11: Test mode fires emitter, laser disabled
// R12: Normal mode: high gain, 3 MHz bandwidth
// R13: Host-written laser supply voltage converter
// R14: Host-written compensation gain converter
// R15: Drive test light emitter trigger
// R16: Locations at least 24 bits wide
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module lba_top import lba_pkg::*; #(
  parameter int TRIG_PERIOD = TRIG_PERIOD_CYC,
  parameter int DAC_BITS    = DAC_W
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  // Interrupt
  output logic                     irq,
  // Flash converter
  input  wire logic [ADC_W-1:0]    adc_data,
  output logic                     adc_convert,
  // Optics
  output logic                     laser_trig,
  output logic                     test_light_emitter_trig,
  output logic                     rx_high_gain,
  output logic                     rx_bw_narrow,
  // Analog converters
  output logic [DAC_BITS-1:0]      laser_dac,
  output logic [DAC_BITS-1:0]      comp_dac
);

  localparam int AW = $clog2(PROF_DEPTH);
  localparam logic [PER_W-1:0] PERIOD_RST = PER_W'(TRIG_PERIOD);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  lba_st_t              st_ff, nxt_st;
  lba_cfg_t             cfg_ff, nxt_cfg;
  logic [DAC_BITS-1:0]  ldac_ff, nxt_ldac;
  logic [DAC_BITS-1:0]  cdac_ff, nxt_cdac;
  logic [INT_W-1:0]     ist_ff, nxt_ist;
  logic [INT_W-1:0]     ien_ff, nxt_ien;
  logic [CNT_W-1:0]     pcnt_ff, nxt_pcnt;
  logic [31:0]          rdata_ff, nxt_rdata;
  logic                 clear_go, clr_busy, clr_done;
  logic                 start, last_pulse;
  logic [INT_W-1:0]     ev;
  lba_tmr_t             tmr;
  logic [ACC_W-1:0]     prof_q;
  logic                 in_prof;

  // Sample path state
  logic [ADC_W-1:0]     samp_ff, nxt_samp;
  logic [AW-1:0]        sidx_ff, nxt_sidx;
  logic                 add_ff, nxt_add;
  logic                 ltrig_ff, nxt_ltrig;
  logic                 etrig_ff, nxt_etrig;
  logic                 conv_ff, nxt_conv;

  assign in_prof    = addr[ADDR_W-1];
  assign start      = wr && hit(addr, OFS_CTRL) && wdata[CTRL_START];
  assign last_pulse = tmr.pulse_end && (pcnt_ff == cfg_ff.pulses - CNT_W'(1));

  // Run control and registers
  always_comb begin
    nxt_st    = st_ff;
    nxt_cfg   = cfg_ff;
    nxt_ldac  = ldac_ff;
    nxt_cdac  = cdac_ff;
    nxt_ien   = ien_ff;
    nxt_pcnt  = pcnt_ff;
    clear_go  = 1'b0;
    ev        = '0;
    case (st_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_st   = ST_CLEAR;
          clear_go = 1'b1; // R06
          nxt_pcnt = '0;
        end
      end
      ST_CLEAR: begin
        if (clr_done) begin
          nxt_st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (last_pulse) begin
          nxt_st          = ST_IDLE; // R03
          ev[INT_DONE]    = 1'b1; // R08
          nxt_pcnt        = pcnt_ff + CNT_W'(1);
        end else if (tmr.pulse_end) begin
          nxt_pcnt = pcnt_ff + CNT_W'(1);
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (start && st_ff != ST_IDLE) begin
      ev[INT_REFUSED] = 1'b1;
    end
    // Settings are frozen during a run
    if (wr && st_ff == ST_IDLE) begin // R01
      if (hit(addr, OFS_CTRL)) begin
        nxt_cfg.test_mode = wdata[CTRL_TEST];
        nxt_cfg.tst_gain  = wdata[CTRL_TST_GAIN];
        nxt_cfg.tst_bw    = wdata[CTRL_TST_BW];
      end else if (hit(addr, OFS_PERIOD)) begin
        nxt_cfg.period = wdata[PER_W-1:0]; // R02
      end else if (hit(addr, OFS_PULSES)) begin
        nxt_cfg.pulses = wdata[CNT_W-1:0];
      end else if (hit(addr, OFS_SAMPLES)) begin
        nxt_cfg.nsamp = wdata[IDX_W-1:0];
      end else if (hit(addr, OFS_PRE)) begin
        nxt_cfg.pre = wdata[IDX_W-1:0];
      end
    end
    if (wr) begin
      if (hit(addr, OFS_LASER_DAC)) begin
        nxt_ldac = wdata[DAC_BITS-1:0]; // R13
      end else if (hit(addr, OFS_COMP_DAC)) begin
        nxt_cdac = wdata[DAC_BITS-1:0]; // R14
      end else if (hit(addr, OFS_INT_EN)) begin
        nxt_ien = wdata[INT_W-1:0];
      end
    end
    // New events win over a clear in the same cycle
    nxt_ist = ist_ff;
    if (wr && hit(addr, OFS_INT_CLR)) begin
      nxt_ist = ist_ff & ~wdata[INT_W-1:0];
    end
    nxt_ist = nxt_ist | ev;
    nxt_rdata = '0;
    if (rd) begin
      if (in_prof) begin
        nxt_rdata = 32'(prof_q); // R09
      end else if (hit(addr, OFS_CTRL)) begin
        nxt_rdata = 32'({cfg_ff.tst_bw, cfg_ff.tst_gain,
                         cfg_ff.test_mode, 1'b0});
      end else if (hit(addr, OFS_STATUS)) begin
        nxt_rdata = 32'({st_ff == ST_RUN, st_ff == ST_CLEAR,
                         st_ff != ST_IDLE});
      end else if (hit(addr, OFS_PERIOD)) begin
        nxt_rdata = 32'(cfg_ff.period);
      end else if (hit(addr, OFS_PULSES)) begin
        nxt_rdata = 32'(cfg_ff.pulses);
      end else if (hit(addr, OFS_SAMPLES)) begin
        nxt_rdata = 32'(cfg_ff.nsamp);
      end else if (hit(addr, OFS_PRE)) begin
        nxt_rdata = 32'(cfg_ff.pre);
      end else if (hit(addr, OFS_LASER_DAC)) begin
        nxt_rdata = 32'(ldac_ff);
      end else if (hit(addr, OFS_COMP_DAC)) begin
        nxt_rdata = 32'(cdac_ff);
      end else if (hit(addr, OFS_INT_STAT)) begin
        nxt_rdata = 32'(ist_ff);
      end else if (hit(addr, OFS_INT_EN)) begin
        nxt_rdata = 32'(ien_ff);
      end else if (hit(addr, OFS_PULSE_CNT)) begin
        nxt_rdata = 32'(pcnt_ff);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff    <= ST_IDLE;
      cfg_ff   <= '{test_mode: 1'b0, tst_gain: 1'b0, tst_bw: 1'b0,
                    period: PERIOD_RST, pulses: PULSES_DEF,
                    nsamp: SAMPLES_DEF, pre: PRE_DEF};
      ldac_ff  <= DAC_BITS'(DAC_DEF);
      cdac_ff  <= DAC_BITS'(DAC_DEF);
      ist_ff   <= '0;
      ien_ff   <= '0;
      pcnt_ff  <= '0;
      rdata_ff <= '0;
    end else begin
      st_ff    <= nxt_st;
      cfg_ff   <= nxt_cfg;
      ldac_ff  <= nxt_ldac;
      cdac_ff  <= nxt_cdac;
      ist_ff   <= nxt_ist;
      ien_ff   <= nxt_ien;
      pcnt_ff  <= nxt_pcnt;
      rdata_ff <= nxt_rdata;
    end
  end

  // Sample capture and trigger outputs
  always_comb begin
    nxt_add   = tmr.sample_stb;
    nxt_samp  = tmr.sample_stb ? adc_data : samp_ff; // R05
    nxt_sidx  = tmr.sample_stb ? tmr.idx[AW-1:0] : sidx_ff; // R07
    nxt_conv  = tmr.sample_stb;
    nxt_ltrig = tmr.trig && !cfg_ff.test_mode; // R02 R11
    nxt_etrig = tmr.trig && cfg_ff.test_mode; // R11 R15
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      samp_ff  <= '0;
      sidx_ff  <= '0;
      add_ff   <= 1'b0;
      conv_ff  <= 1'b0;
      ltrig_ff <= 1'b0;
      etrig_ff <= 1'b0;
    end else begin
      samp_ff  <= nxt_samp;
      sidx_ff  <= nxt_sidx;
      add_ff   <= nxt_add;
      conv_ff  <= nxt_conv;
      ltrig_ff <= nxt_ltrig;
      etrig_ff <= nxt_etrig;
    end
  end

  lba_timer u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .run     (st_ff == ST_RUN),
    .cfg     (cfg_ff),
    .tmr     (tmr)
  );

  lba_accum u_accum (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clear_go (clear_go),
    .clr_busy (clr_busy),
    .clr_done (clr_done),
    .add_en   (add_ff),
    .add_idx  (sidx_ff),
    .add_val  (samp_ff),
    .rd_idx   (addr[AW+1:2]),
    .rd_data  (prof_q)
  );

  assign rdata        = rdata_ff;
  assign irq          = |(ist_ff & ien_ff);
  assign adc_convert  = conv_ff;
  assign laser_trig   = ltrig_ff;
  assign test_light_emitter_trig = etrig_ff;
  assign rx_high_gain = !cfg_ff.test_mode || cfg_ff.tst_gain; // R12
  assign rx_bw_narrow = !cfg_ff.test_mode || cfg_ff.tst_bw; // R12
  assign laser_dac    = ldac_ff;
  assign comp_dac     = cdac_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  laser_off_test_a: assert property (cfg_ff.test_mode |-> !laser_trig) // R11
    else $error("laser fired in test mode");
  emitter_fire_a: assert property ( // R15
    $rose(tmr.trig) && cfg_ff.test_mode |=> test_light_emitter_trig)
    else $error("test emitter not triggered");
  sample_space_a: assert property ( // R04
    tmr.sample_stb |=> (!tmr.sample_stb)[*8] ##1 !tmr.sample_stb)
    else $error("samples closer than 100 ns");
  prelaunch_a: assert property ( // R10
    $rose(ltrig_ff) |-> sidx_ff == cfg_ff.pre[AW-1:0]
    && $past(tmr.idx) == cfg_ff.pre)
    else $error("launch not after pre-launch samples");
  clear_first_a: assert property ( // R06
    $rose(st_ff == ST_RUN) |-> $past(clr_done))
    else $error("run started without clear");
  count_end_a: assert property ( // R03 R08
    st_ff == ST_RUN && tmr.pulse_end
    && pcnt_ff == cfg_ff.pulses - CNT_W'(1)
    |=> st_ff == ST_IDLE && ist_ff[INT_DONE])
    else $error("run end or done flag wrong");
  capture_a: assert property ( // R05 R07
    tmr.sample_stb |=> add_ff && samp_ff == $past(adc_data)
    && sidx_ff == $past(tmr.idx[AW-1:0]))
    else $error("sample capture mismatch");
  normal_gain_a: assert property ( // R12
    !cfg_ff.test_mode |-> rx_high_gain && rx_bw_narrow)
    else $error("normal mode gain or bandwidth wrong");
  laser_dac_a: assert property ( // R13
    wr && addr == OFS_LASER_DAC
    |=> laser_dac == $past(wdata[DAC_BITS-1:0]))
    else $error("laser converter not updated");
  comp_dac_a: assert property ( // R14
    wr && addr == OFS_COMP_DAC
    |=> comp_dac == $past(wdata[DAC_BITS-1:0]))
    else $error("compensation converter not updated");
  frozen_cfg_a: assert property (st_ff != ST_IDLE |=> $stable(cfg_ff)) // R01
    else $error("settings changed during run");

  run_done_c: cover property (st_ff == ST_RUN ##1 st_ff == ST_IDLE);
  test_fire_c: cover property (test_light_emitter_trig);
  irq_c: cover property ($rose(irq));
  refused_c: cover property (ev[INT_REFUSED]);

endmodule

// ### dv/lba_rx_model.sv
// Receiver and flash converter model feeding sample bytes
`timescale 1ns/10ps
module lba_rx_model import lba_pkg::*; (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Run framing from bench
  input  wire logic             restart,
  input  wire logic [IDX_W-1:0] nsamp,
  // Converter
  input  wire logic             adc_convert,
  output logic      [ADC_W-1:0] adc_data
);
  logic [IDX_W-1:0] idx_ff;
  logic [IDX_W-1:0] nxt_idx;
  logic [3:0]       pls_ff;
  logic [3:0]       nxt_pls;

  // Slot and pulse position, stepped by each conversion
  always_comb begin
    nxt_idx = idx_ff;
    nxt_pls = pls_ff;
    if (restart) begin
      nxt_idx = '0;
      nxt_pls = '0;
    end else if (adc_convert) begin
      if (idx_ff == nsamp - 10'h001) begin
        nxt_idx = '0;
        nxt_pls = pls_ff + 4'h1;
      end else begin
        nxt_idx = idx_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      idx_ff <= '0;
      pls_ff <= '0;
    end else begin
      idx_ff <= nxt_idx;
      pls_ff <= nxt_pls;
    end
  end

  // Byte held until next conversion
  assign adc_data = 8'h80 + {1'b0, pls_ff, 3'b000} + idx_ff[ADC_W-1:0];
endmodule

// ### dv/tb_top.sv
// Register-level testbench of the backscatter accumulator
`timescale 1ns/10ps
module tb_top import lba_pkg::*;;
  logic              clk_sys, reset, wr, rd, restart, irq, adc_convert;
  logic              laser_trig, test_light_emitter_trig, trig_q, led_q;
  logic              rx_high_gain, rx_bw_narrow;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata, rdata, rv;
  logic [ADC_W-1:0]  adc_data;
  logic [DAC_W-1:0]  laser_dac, comp_dac;
  int                fail_count, n_compared, n_laser, n_led, n_conv;
  int                per_err, pre_err, cyc, t_rise;

  lba_top #(.TRIG_PERIOD(6000)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .adc_data(adc_data),
    .adc_convert(adc_convert), .laser_trig(laser_trig),
    .test_light_emitter_trig(test_light_emitter_trig),
    .rx_high_gain(rx_high_gain), .rx_bw_narrow(rx_bw_narrow),
    .laser_dac(laser_dac), .comp_dac(comp_dac));

  lba_rx_model i_rx (
    .clk_sys(clk_sys), .reset(reset), .restart(restart),
    .nsamp(10'h008), .adc_convert(adc_convert), .adc_data(adc_data));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Trigger and conversion monitor
  always @(posedge clk_sys) begin
    cyc++;
    trig_q <= laser_trig;
    led_q  <= test_light_emitter_trig;
    if (adc_convert === 1'b1) n_conv++;
    if (laser_trig === 1'b1 && trig_q === 1'b0) begin
      n_laser++;
      if (n_laser > 1 && cyc - t_rise != 100) per_err++;
      t_rise = cyc;
      if (i_rx.idx_ff === '0) pre_err++;
    end
    if (test_light_emitter_trig === 1'b1 && led_q === 1'b0) n_led++;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    rd_reg(a, rv);
    chk(rv, e);
  endtask

  // Host waits on the interrupt line or polls the busy bit
  task automatic wait_done(input bit use_irq);
    int i;
    for (i = 0; i < 3000; i++) begin
      if (use_irq) begin
        @(posedge clk_sys);
        #1;
        if (irq === 1'b1) return;
      end else begin
        rd_reg(OFS_STATUS, rv);
        if (rv[0] === 1'b0) return;
      end
    end
    fail_count++;
    $display("[ERR] t=%0t wait expired got=%h exp=%h", $time, rv, 32'h0);
    results();
  endtask

  task automatic start(input logic [31:0] ctrl);
    @(posedge clk_sys);
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
    n_laser = 0;
    n_led   = 0;
    n_conv  = 0;
    per_err = 0;
    pre_err = 0;
    wr_reg(OFS_CTRL, ctrl);
  endtask

  function automatic logic [31:0] prof(input int k);
    return (k < 8) ? 32'(3 * (32'h80 + k) + 32'h18) : 32'h0;
  endfunction

  task automatic chk_profile();
    int k;
    for (k = 0; k < 9; k++) begin
      rd_chk(OFS_PROFILE + ADDR_W'(4 * k), prof(k));
    end
  endtask

  initial begin
    {reset, wr, rd, restart, trig_q, led_q} = 6'b100000;
    addr  = '0;
    wdata = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values and unmapped read
    #1 chk(32'(irq), 32'h0);
    chk(32'(rx_high_gain), 32'h1);
    chk(32'(rx_bw_narrow), 32'h1);
    rd_chk(OFS_PERIOD, 32'h1770);
    rd_chk(OFS_PULSES, 32'h10000);
    rd_chk(OFS_SAMPLES, 32'h1F4);
    rd_chk(OFS_PRE, 32'h4);
    rd_chk(OFS_INT_STAT, 32'h0);
    rd_chk(12'h030, 32'h0);
    $display("test reset_values done");
    // Converter outputs
    wr_reg(OFS_LASER_DAC, 32'hABC);
    wr_reg(OFS_COMP_DAC, 32'h123);
    @(posedge clk_sys);
    #1 chk(32'(laser_dac), 32'hABC);
    chk(32'(comp_dac), 32'h123);
    rd_chk(OFS_LASER_DAC, 32'hABC);
    rd_chk(OFS_COMP_DAC, 32'h123);
    $display("test converters done");
    // Normal run with refused restart
    wr_reg(OFS_PERIOD, 32'h64);
    wr_reg(OFS_SAMPLES, 32'h8);
    wr_reg(OFS_PULSES, 32'h3);
    wr_reg(OFS_PRE, 32'h2);
    wr_reg(OFS_INT_EN, 32'h1);
    start(32'h1);
    wr_reg(OFS_CTRL, 32'h1);
    rd_chk(OFS_STATUS, 32'h3);
    rd_chk(OFS_INT_STAT, 32'h2);
    chk(32'(irq), 32'h0);
    chk(32'(rx_high_gain), 32'h1);
    wait_done(1'b1);
    chk(32'(n_laser), 32'h3);
    chk(32'(n_led), 32'h0);
    chk(32'(per_err), 32'h0);
    chk(32'(pre_err), 32'h0);
    chk(32'(n_conv), 32'h18);
    rd_chk(OFS_INT_STAT, 32'h3);
    rd_chk(OFS_PULSE_CNT, 32'h3);
    chk_profile();
    $display("test normal_run done");
    // Interrupt clear
    wr_reg(OFS_INT_CLR, 32'h3);
    rd_chk(OFS_INT_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test irq_clear done");
    // Test mode run, masked interrupt
    wr_reg(OFS_INT_EN, 32'h0);
    wr_reg(OFS_CTRL, 32'h6);
    rd_chk(OFS_CTRL, 32'h6);
    chk(32'(rx_high_gain), 32'h1);
    chk(32'(rx_bw_narrow), 32'h0);
    start(32'hB);
    wait_done(1'b0);
    @(posedge clk_sys);
    #1 chk(32'(irq), 32'h0);
    rd_chk(OFS_INT_STAT, 32'h1);
    chk(32'(rx_high_gain), 32'h0);
    chk(32'(rx_bw_narrow), 32'h1);
    chk(32'(n_laser), 32'h0);
    chk(32'(n_led), 32'h3);
    chk_profile();
    wr_reg(OFS_INT_EN, 32'h1);
    @(posedge clk_sys);
    #1 chk(32'(irq), 32'h1);
    wr_reg(OFS_INT_CLR, 32'h1);
    @(posedge clk_sys);
    #1 chk(32'(irq), 32'h0);
    $display("test test_mode done");
    results();
  end
endmodule
